// [design/usb_endpoint_pingpong_out.sv]
/*
 * usb_endpoint_pingpong_out: ping-pong out endpoint, fifo data port,
 * byte counts and usb event flags. assumes: serial engine delivers
 * packet-level events synchronous to clk; firmware at the register port.
 */
`timescale 1ns/1ps
module usb_endpoint_pingpong_out
	import usb_ep_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrWr,
	input wire logic sfrRd,
	output logic [7:0] sfrRdData,
	// firmware control
	input wire logic [EP_W-1:0] endpointSelectField,
	input wire logic endpointEnable,
	input wire logic stallRequest,
	input wire logic [N_FLAGS-1:0] flagClear,
	input wire logic [N_FLAGS-1:0] flagEnable,
	output logic [N_FLAGS-1:0] eventFlags,
	output logic usbIrq,
	// serial engine side
	input wire sieRx_t sieRx,
	input wire sieEvt_t sieEvt,
	output logic rxReady,
	output logic hsAck,
	output logic hsNak,
	output logic [7:0] txByte,
	output logic txValid
);
	typedef enum logic [1:0] {RX_IDLE, RX_RECV, RX_DROP} rxState_t;

	rxState_t st_q, st_d; // receive state
	logic [N_FLAGS-1:0] flg_q, flg_d; // sticky event flags
	logic [CNT_W-1:0] cnt0_q, cnt0_d; // bank 0 byte count
	logic [CNT_W-1:0] cnt1_q, cnt1_d; // bank 1 byte count
	logic [CNT_W-1:0] run_q, run_d; // bytes of packet in flight
	logic rxBank_q, rxBank_d; // bank the next packet fills
	logic fwBank_q, fwBank_d; // bank firmware reads
	logic ovf_q, ovf_d; // packet overran the fifo
	logic susp_q, susp_d; // bus in suspend
	logic [7:0] rd_q, rd_d; // register read data
	logic [7:0] tx_q, tx_d; // byte to send
	logic txv_q, txv_d; // byte to send valid
	logic fifoPush, fifoCommit, fifoRewind;
	logic popValid, popReq;
	logic [DATA_W-1:0] popData;
	logic [N_FLAGS-1:0] setEv; // hardware set pulses
	logic [CNT_W-1:0] fwCnt; // count for firmware bank

	// true when the register port addresses the ping-pong endpoint
	function automatic logic epHit(input logic [EP_W-1:0] sel);
		return sel == PP_EP_NUM;
	endfunction

	// ****************************************
	// data fifo
	// ****************************************
	usb_byte_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.inValid(fifoPush),
		.inReady(rxReady),
		.inData(sieRx.byteData),
		.commit(fifoCommit),
		.rewind(fifoRewind),
		.outValid(popValid),
		.outReady(popReq),
		.outData(popData)
	);

	// ****************************************
	// receive state, flags and counts
	// ****************************************
	// next state of the receive path
	always_comb
	begin
		st_d = st_q;
		cnt0_d = cnt0_q;
		cnt1_d = cnt1_q;
		run_d = run_q;
		rxBank_d = rxBank_q;
		fwBank_d = fwBank_q;
		ovf_d = ovf_q;
		susp_d = susp_q;
		setEv = '0;
		hsAck = 1'b0;
		hsNak = 1'b0;
		fifoPush = 1'b0;
		fifoCommit = 1'b0;
		fifoRewind = 1'b0;
		case (st_q)
			RX_IDLE:
			begin
				// disabled endpoint takes nothing
				if (sieRx.outToken && endpointEnable)
				begin
					run_d = '0;
					ovf_d = 1'b0;
					// full bank answers nak
					if (flg_q[rxBank_q ? F_BANK1 : F_BANK0])
						st_d = RX_DROP;
					else
						st_d = RX_RECV;
				end
			end
			RX_RECV:
			begin
				if (sieRx.byteValid)
				begin
					fifoPush = 1'b1;
					if (rxReady)
						run_d = run_q + 1'b1;
					else
						ovf_d = 1'b1;
				end
				if (sieRx.pktEnd)
				begin
					st_d = RX_IDLE;
					if (sieRx.pktGood && !ovf_q)
					begin
						hsAck = 1'b1;
						fifoCommit = 1'b1;
						rxBank_d = ~rxBank_q;
						if (rxBank_q)
						begin
							setEv[F_BANK1] = 1'b1;
							cnt1_d = run_q;
						end
						else
						begin
							setEv[F_BANK0] = 1'b1;
							cnt0_d = run_q;
						end
					end
					else
					begin
						fifoRewind = 1'b1;
						hsNak = ovf_q; // overrun is retried by the host
					end
				end
			end
			RX_DROP:
			begin
				if (sieRx.pktEnd)
				begin
					hsNak = 1'b1;
					st_d = RX_IDLE;
				end
			end
			default:
				st_d = RX_IDLE;
		endcase
		// bus events
		setEv[F_IN_DONE] = sieEvt.inAcked;
		setEv[F_SETUP] = sieEvt.setupTaken;
		setEv[F_STALL] = sieEvt.stallSent && stallRequest;
		setEv[F_SOF] = sieEvt.sofSeen;
		setEv[F_SUSP] = sieEvt.suspendSeen;
		setEv[F_WAKE] = sieEvt.resumeSeen && susp_q;
		if (sieEvt.suspendSeen)
			susp_d = 1'b1;
		else if (sieEvt.resumeSeen)
			susp_d = 1'b0;
		// set wins over clear
		flg_d = (flg_q & ~flagClear) | setEv;
		if (sieEvt.setupTaken)
			flg_d[F_STALL] = 1'b0;
		// firmware drained its bank: move to the other one
		if (flg_q[fwBank_q ? F_BANK1 : F_BANK0] && !flg_d[fwBank_q ? F_BANK1 : F_BANK0])
			fwBank_d = ~fwBank_q;
	end

	// receive path registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q <= RX_IDLE;
			flg_q <= '0;
			cnt0_q <= '0;
			cnt1_q <= '0;
			run_q <= '0;
			rxBank_q <= 1'b0;
			fwBank_q <= 1'b0;
			ovf_q <= 1'b0;
			susp_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			flg_q <= flg_d;
			cnt0_q <= cnt0_d;
			cnt1_q <= cnt1_d;
			run_q <= run_d;
			rxBank_q <= rxBank_d;
			fwBank_q <= fwBank_d;
			ovf_q <= ovf_d;
			susp_q <= susp_d;
		end
	end

	assign eventFlags = flg_q;
	assign usbIrq = |(flg_q & flagEnable);

	// ****************************************
	// register port
	// ****************************************
	// read mux, fifo pop and transmit push
	always_comb
	begin
		fwCnt = fwBank_q ? cnt1_q : cnt0_q;
		popReq = sfrRd && sfrAddr == ADDR_FIFO_DATA && epHit(endpointSelectField);
		rd_d = rd_q;
		tx_d = tx_q;
		txv_d = 1'b0;
		if (sfrRd)
		begin
			case (sfrAddr)
				ADDR_FIFO_DATA:
					rd_d = (popReq && popValid) ? popData : RST_RD_DATA;
				ADDR_BYTE_CNT_LO:
					rd_d = epHit(endpointSelectField) ? fwCnt[7:0] : RST_BYTE_CNT;
				ADDR_BYTE_CNT_HI:
					rd_d = epHit(endpointSelectField) ? {5'h00, fwCnt[CNT_W-1:8]}
						: RST_BYTE_CNT;
				default:
					rd_d = RST_RD_DATA; // unmapped reads zero
			endcase
		end
		if (sfrWr && sfrAddr == ADDR_FIFO_DATA)
		begin
			tx_d = sfrWrData;
			txv_d = 1'b1;
		end
	end

	// register port registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_q <= RST_RD_DATA;
			tx_q <= RST_RD_DATA;
			txv_q <= 1'b0;
		end
		else
		begin
			rd_q <= rd_d;
			tx_q <= tx_d;
			txv_q <= txv_d;
		end
	end

	assign sfrRdData = rd_q;
	assign txByte = tx_q;
	assign txValid = txv_q;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_bank0_set: assert property (hsAck && !rxBank_q |=> flg_q[F_BANK0])
		else $error("bank 0 flag not set after good packet");
	a_bank1_set: assert property (hsAck && rxBank_q |=> flg_q[F_BANK1] && cnt1_q == $past(run_q))
		else $error("bank 1 flag or count wrong after good packet");
	a_zlp_count: assert property (hsAck && run_q == '0 && !rxBank_q |=> cnt0_q == '0)
		else $error("zero length packet count not zero");
	a_bank_swap: assert property ($fell(flg_q[F_BANK0]) && !$past(fwBank_q) |-> fwBank_q)
		else $error("bank not swapped on flag clear");
	a_nak_full: assert property (st_q == RX_DROP && sieRx.pktEnd |-> hsNak && !hsAck)
		else $error("full bank not answered with nak");
	a_bank_alternate: assert property (hsAck |=> rxBank_q != $past(rxBank_q))
		else $error("bank order did not alternate");
	a_in_done: assert property (sieEvt.inAcked |=> flg_q[F_IN_DONE])
		else $error("in complete flag lost");
	a_setup_stall: assert property (sieEvt.setupTaken |=> flg_q[F_SETUP] && !flg_q[F_STALL])
		else $error("setup flag or stall clear wrong");
	a_frame_wake: assert property (sieEvt.sofSeen || (sieEvt.resumeSeen && susp_q)
		|=> (flg_q[F_SOF] || !$past(sieEvt.sofSeen))
		&& (flg_q[F_WAKE] || !$past(sieEvt.resumeSeen && susp_q)))
		else $error("frame or wakeup flag lost");
	a_hi_reserved: assert property (sfrRd && sfrAddr == ADDR_BYTE_CNT_HI |=> sfrRdData[7:3] == 5'h00)
		else $error("reserved count bits not zero");
	a_irq_level: assert property (usbIrq && flagClear == '0
		|=> usbIrq || flagEnable != $past(flagEnable))
		else $error("irq dropped while its flag stood");
endmodule // usb_endpoint_pingpong_out

// [pkg/usb_ep_pkg.sv]
/*
 * usb_ep_pkg: constants and carrier types for the ping-pong OUT endpoint.
 * assumes: one clock domain, byte-wide special-function register port.
 */
package usb_ep_pkg;
	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [7:0] ADDR_FIFO_DATA = 8'hcf; // endpoint_fifo_data
	localparam logic [7:0] ADDR_BYTE_CNT_LO = 8'he2; // endpoint_byte_count_low
	localparam logic [7:0] ADDR_BYTE_CNT_HI = 8'he3; // endpoint_byte_count_high
	localparam logic [7:0] RST_BYTE_CNT = 8'h00; // count reset value
	localparam logic [7:0] RST_RD_DATA = 8'h00; // read data reset value

	// ****************************************
	// sizes
	// ****************************************
	localparam int DATA_W = 8; // fifo word width
	localparam int FIFO_DEPTH = 32; // fifo depth in words
	localparam int CNT_W = 11; // received byte count width
	localparam int CNT_HI_W = 3; // count bits in the high register
	localparam int EP_W = 4; // endpoint number width
	localparam logic [3:0] PP_EP_NUM = 4'h1; // endpoint number of the ping-pong endpoint

	// ****************************************
	// event flag positions
	// ****************************************
	localparam int N_FLAGS = 8;
	localparam int F_IN_DONE = 0; // in_transfer_complete
	localparam int F_BANK0 = 1; // out_bank0_received
	localparam int F_SETUP = 2; // setup_received
	localparam int F_STALL = 3; // stall_sent_flag
	localparam int F_BANK1 = 4; // out_bank1_received
	localparam int F_SOF = 5; // frame_start_event
	localparam int F_WAKE = 6; // wakeup_event
	localparam int F_SUSP = 7; // suspend_event

	// ****************************************
	// carriers
	// ****************************************
	// packet-level events from the serial engine
	typedef struct packed {
		logic outToken; // out token for this endpoint
		logic byteValid; // one received data byte
		logic [7:0] byteData; // the received byte
		logic pktEnd; // end of the data packet
		logic pktGood; // packet crc and pid good
	} sieRx_t;

	// bus events from the serial engine
	typedef struct packed {
		logic inAcked; // host acked an in packet
		logic setupTaken; // setup packet accepted
		logic stallSent; // stall handshake went out
		logic sofSeen; // start of frame received
		logic suspendSeen; // bus suspend detected
		logic resumeSeen; // bus resume detected
	} sieEvt_t;
endpackage

// [design/usb_byte_fifo.sv]
/*
 * usb_byte_fifo: byte fifo with a committed write pointer so that a bad
 * packet can be withdrawn. assumes: one clock, writer commits or rewinds.
 */
`timescale 1ns/1ps
module usb_byte_fifo
	import usb_ep_pkg::*;
#(
	parameter int WIDTH = DATA_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// filling side
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	input wire logic commit, // make written words visible
	input wire logic rewind, // drop uncommitted words
	// draining side
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW:0] wr_q, wr_d; // tentative write pointer
	logic [AW:0] cmt_q, cmt_d; // committed write pointer
	logic [AW:0] rd_q, rd_d; // read pointer
	logic [AW:0] used; // words held, committed or not

	// ****************************************
	// pointers
	// ****************************************
	// next pointer values
	always_comb
	begin
		used = wr_q - rd_q;
		inReady = used != (AW+1)'(DEPTH); // full only at depth words
		outValid = cmt_q != rd_q;
		wr_d = wr_q;
		cmt_d = cmt_q;
		rd_d = rd_q;
		if (rewind)
			wr_d = cmt_q; // withdraw the bad packet
		else if (inValid && inReady)
			wr_d = wr_q + 1'b1;
		if (commit)
			cmt_d = wr_q;
		if (outValid && outReady)
			rd_d = rd_q + 1'b1;
	end

	// pointer registers
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_q <= '0;
			cmt_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			cmt_q <= cmt_d;
			rd_q <= rd_d;
		end
	end

	// storage write and registered read, no reset on the array
	// a word is committed at least one edge after it is written, so the
	// read register, refreshed every edge from the next read pointer,
	// always holds the committed word at the head
	always_ff @(posedge clk)
	begin
		if (inValid && inReady && !rewind)
			mem[wr_q[AW-1:0]] <= inData;
		outData <= mem[rd_d[AW-1:0]]; // head word, one edge ahead
	end
endmodule // usb_byte_fifo

// [testbench/usb_host_model.sv]
/*
 * usb_host_model: host side of the out pipe plus bus event pulses.
 * assumes: tasks called from the bench, single clk, changes 1 ns after edges.
 */
`timescale 1ns/1ps
module usb_host_model
	import usb_ep_pkg::*;
(
	// clock
	input wire logic clk,
	// toward the endpoint
	output sieRx_t sieRx,
	output sieEvt_t sieEvt
);
	// ****************************************
	// stimulus
	// ****************************************
	// idle at time zero
	initial
	begin
		sieRx = '0;
		sieEvt = '0;
	end

	// token, bytes with random stalls, end; gap and end-cycle data is inverted
	task automatic send(input logic [7:0] d[$], input logic good);
		logic [7:0] last;
		last = 8'h00;
		@(posedge clk) #1 sieRx = '{1'b1, 1'b0, 8'h00, 1'b0, 1'b0};
		foreach (d[i])
		begin
			@(posedge clk) #1;
			// slow host: a gap cycle now and then
			if ($urandom_range(1) == 1)
			begin
				sieRx = '{1'b0, 1'b0, ~last, 1'b0, 1'b0};
				@(posedge clk) #1;
			end
			sieRx = '{1'b0, 1'b1, d[i], 1'b0, 1'b0};
			last = d[i];
		end
		@(posedge clk) #1 sieRx = '{1'b0, 1'b0, ~last, 1'b1, good};
		@(posedge clk) #1 sieRx = '{1'b0, 1'b0, last, 1'b0, 1'b0};
	endtask

	// one-cycle bus event pulse
	task automatic evt(input int b);
		@(posedge clk) #1 sieEvt = sieEvt_t'(6'h01 << b);
		@(posedge clk) #1 sieEvt = '0;
	endtask
endmodule // usb_host_model

// [testbench/tb_top.sv]
/*
 * tb_top: self-checking bench for the ping-pong out endpoint.
 * assumes: usb_host_model drives the serial side; bench plays firmware.
 */
`timescale 1ns/1ps
module tb_top
	import usb_ep_pkg::*;
;
	// ****************************************
	// signals
	// ****************************************
	localparam logic [7:0] ACK = 8'h02; // {hsAck, hsNak}
	localparam logic [7:0] NAK = 8'h01;
	localparam logic [7:0] NONE = 8'h00;
	logic clk, rst_n, sfrWr, sfrRd, endpointEnable, stallRequest, rdWas;
	logic [7:0] sfrAddr, sfrWrData, sfrRdData, txByte, flagClear, flagEnable, eventFlags;
	logic [EP_W-1:0] endpointSelectField;
	logic usbIrq, rxReady, hsAck, hsNak, txValid;
	sieRx_t sieRx;
	sieEvt_t sieEvt;
	logic [7:0] rdQ[$]; // expected read data
	logic [7:0] hsQ[$]; // expected handshakes
	logic [7:0] accQ[$]; // accepted bytes in fifo order
	int num_errors = 0;
	int check_count = 0;

	usb_endpoint_pingpong_out dut (.clk(clk), .rst_n(rst_n), .sfrAddr(sfrAddr),
		.sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData),
		.endpointSelectField(endpointSelectField), .endpointEnable(endpointEnable),
		.stallRequest(stallRequest), .flagClear(flagClear), .flagEnable(flagEnable),
		.eventFlags(eventFlags), .usbIrq(usbIrq), .sieRx(sieRx), .sieEvt(sieEvt),
		.rxReady(rxReady), .hsAck(hsAck), .hsNak(hsNak), .txByte(txByte),
		.txValid(txValid));
	usb_host_model host (.clk(clk), .sieRx(sieRx), .sieEvt(sieEvt));

	// 20 MHz clock
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ****************************************
	// checking
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// watcher: read data the cycle after a read, handshakes as they come
	initial rdWas = 1'b0;
	always @(negedge clk)
	begin
		if (rdWas)
			check(sfrRdData, rdQ.size() > 0 ? rdQ.pop_front() : 8'hxx);
		if ((hsAck | hsNak) === 1'b1)
			check({6'h00, hsAck, hsNak}, hsQ.size() > 0 ? hsQ.pop_front() : 8'hxx);
		rdWas = sfrRd;
	end

	task automatic close_out;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("[FAIL] %0t run timed out", $time);
		close_out();
	end

	// ****************************************
	// firmware and host tasks
	// ****************************************
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) #1;
		sfrRd = 1'b1;
		sfrAddr = a;
		rdQ.push_back(e);
		@(posedge clk) #1 sfrRd = 1'b0;
	endtask

	task automatic clr(input int f);
		@(posedge clk) #1 flagClear = 8'h01 << f;
		@(posedge clk) #1 flagClear = 8'h00;
	endtask

	// random packet; note bytes and handshake expected
	task automatic pkt(input int n, input logic [7:0] hs, input logic good = 1'b1);
		logic [7:0] q[$];
		repeat (n) q.push_back(8'($urandom));
		if (hs == ACK)
			accQ = {accQ, q};
		if (hs != NONE)
			hsQ.push_back(hs);
		host.send(q, good);
		@(posedge clk) #1;
	endtask

	task automatic drain(input int n);
		repeat (n) rd(ADDR_FIFO_DATA, accQ.pop_front());
	endtask

	task automatic ev(input int b, input int f, input logic e);
		host.evt(b);
		check({7'h00, eventFlags[f]}, {7'h00, e});
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		{sfrAddr, sfrWrData, sfrWr, sfrRd, flagClear, stallRequest, endpointEnable} = '0;
		endpointSelectField = PP_EP_NUM;
		flagEnable = 8'hff;
		rst_n = 1'b0;
		void'($urandom(40));
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		rd(ADDR_BYTE_CNT_LO, RST_BYTE_CNT);
		rd(ADDR_BYTE_CNT_HI, RST_BYTE_CNT);
		check(eventFlags, 8'h00);
		pkt(2, NONE);
		check(eventFlags, 8'h00);
		$display("test reset and disabled done");
		endpointEnable = 1'b1;
		pkt(3, ACK);
		check({7'h00, usbIrq}, 8'h01);
		pkt(2, ACK);
		check(eventFlags, 8'h12);
		pkt(1, NAK);
		rd(ADDR_BYTE_CNT_LO, 8'h03);
		rd(ADDR_BYTE_CNT_HI, 8'h00);
		drain(3);
		clr(F_BANK0);
		rd(ADDR_BYTE_CNT_LO, 8'h02);
		pkt(0, ACK);
		pkt(1, NAK);
		drain(2);
		clr(F_BANK1);
		rd(ADDR_BYTE_CNT_LO, 8'h00);
		rd(ADDR_BYTE_CNT_HI, 8'h00);
		rd(ADDR_FIFO_DATA, 8'h00);
		clr(F_BANK0);
		$display("test ping-pong done");
		// overflow is refused, then a full fifo is drained
		pkt(33, NAK);
		// bad packet: bytes withdrawn, no flag, no handshake
		pkt(4, NONE, 1'b0);
		check(eventFlags, 8'h00);
		check({7'h00, rxReady}, 8'h01);
		pkt(32, ACK);
		check({7'h00, rxReady}, 8'h00);
		rd(ADDR_BYTE_CNT_LO, 8'h20);
		drain(32);
		check({7'h00, rxReady}, 8'h01);
		clr(F_BANK1);
		$display("test fifo fill done");
		// transmit byte
		@(posedge clk) #1;
		sfrWr = 1'b1;
		sfrAddr = ADDR_FIFO_DATA;
		sfrWrData = 8'($urandom);
		@(posedge clk) #1 sfrWr = 1'b0;
		check(txByte, sfrWrData);
		check({7'h00, txValid}, 8'h01);
		// bus events
		ev(0, F_WAKE, 1'b0);
		ev(1, F_SUSP, 1'b1);
		ev(0, F_WAKE, 1'b1);
		ev(5, F_IN_DONE, 1'b1);
		ev(2, F_SOF, 1'b1);
		stallRequest = 1'b1;
		ev(3, F_STALL, 1'b1);
		ev(4, F_STALL, 1'b0);
		check({7'h00, eventFlags[F_SETUP]}, 8'h01);
		flagEnable = 8'h00;
		#1 check({7'h00, usbIrq}, 8'h00);
		@(posedge clk) #1 flagClear = 8'hff;
		flagEnable = 8'hff;
		@(posedge clk) #1 flagClear = 8'h00;
		check({7'h00, usbIrq}, 8'h00);
		$display("test events done");
		check(8'(hsQ.size()), 8'h00);
		close_out();
	end
endmodule // tb_top
